// file: core/amc_config.v
/*
 * Configuration register of the analog monitor: mode select with
 * start-qualified activation, interrupt enables, threshold polarity.
 * Assumes a synchronous peripheral bus with single-cycle read and write
 * strobes, and that the control/status register outside supplies the
 * start pulse and the event flag levels.
 */
`timescale 1ns/1ns
`default_nettype none
`include "amc_map.vh"

// Notes on behaviour
// - reset clears all eight configuration bits to zero
// - mode comes from bits 1..0; zero keeps the monitor disabled
// - mode 01 runs one level-measurement burst over all eight inputs
// - mode 10 runs one threshold-comparison burst over all eight inputs
// - mode 11 compares inputs to threshold periodically, low power
// - periodic comparison stops only when another mode is started
// - written mode takes effect only on a start write
// - bit 3 lets the measure-done flag raise the interrupt
// - bit 4 lets the threshold-crossed flag raise the interrupt
// - bit 5 chooses below (0) or above (1) as threshold event
// - start with a new mode clears all flags and begins it; same mode ignored
// - clearing the causing flag drops the interrupt request
module amc_config (
	input  wire                   clk_i,                   // core clock
	input  wire                   rst_i,                   // sync reset
	input  wire [`AMC_ADDR_W-1:0] bus_addr_i,              // byte address
	input  wire                   bus_wr_i,                // write strobe
	input  wire                   bus_rd_i,                // read strobe
	input  wire [7:0]             bus_wdata_i,             // write data
	output reg  [7:0]             bus_rdata_o,             // read data
	input  wire                   start_i,                 // start write
	input  wire                   measure_done_flag_i,     // flag level
	input  wire                   threshold_crossed_flag_i,// flag level
	input  wire                   any_above_i,             // a channel over
	input  wire                   any_below_i,             // a channel under
	output reg  [1:0]             active_mode_o,           // mode in use
	output reg                    flags_clear_o,           // clear pulse
	output reg                    level_burst_o,           // burst pulse
	output reg                    compare_burst_o,         // burst pulse
	output reg                    lowpwr_run_o,            // periodic level
	output reg                    threshold_set_o,         // sets flag
	output reg                    irq_o                    // interrupt
);

	// one-hot record of the mode in use
	localparam [3:0] ST_OFF    = 4'h1;
	localparam [3:0] ST_LEVEL  = 4'h2;
	localparam [3:0] ST_CMP    = 4'h4;
	localparam [3:0] ST_LOWPWR = 4'h8;
	localparam [7:0] CFG_RESET = `AMC_CFG_RESET;
	localparam [7:0] CFG_WMASK = `AMC_CFG_WMASK;

	// storage and field views
	reg  [7:0] monitor_configuration;
	wire [7:0] next_monitor_configuration;
	wire [1:0] monitor_mode_select;
	wire       measure_done_irq_enable;
	wire       threshold_event_irq_enable;
	wire       threshold_polarity_select;

	// bus decode
	wire       cfg_hit;
	wire       cfg_wr;
	wire       cfg_rd;
	wire [7:0] next_bus_rdata;

	// mode sequencing
	reg  [3:0] mode_state;
	reg  [3:0] next_mode_state;
	reg  [3:0] target_state;
	reg  [1:0] next_active_mode;
	wire       mode_change;
	wire       next_level_burst;
	wire       next_compare_burst;
	wire       next_lowpwr_run;

	// event and interrupt paths
	wire       measure_done_req;
	wire       threshold_req;
	wire       selected_crossing;
	wire       next_irq;
	wire       next_threshold_set;

	assign cfg_hit = (bus_addr_i == `AMC_CFG_ADDR);
	assign cfg_wr  = bus_wr_i && cfg_hit;
	assign cfg_rd  = bus_rd_i && cfg_hit;

	// per-bit next value; reserved bits never take a written one
	genvar b;
	generate
		for (b = 0; b < 8; b = b + 1) begin : g_cfg_bit
			if (CFG_WMASK[b]) begin : g_used
				assign next_monitor_configuration[b] = cfg_wr
					? bus_wdata_i[b]
					: monitor_configuration[b];
			end else begin : g_reserved
				assign next_monitor_configuration[b] =
					CFG_RESET[b];
			end
		end
	endgenerate

	always @(posedge clk_i) begin
		if (rst_i) begin
			monitor_configuration <= CFG_RESET;
		end else begin
			monitor_configuration <= next_monitor_configuration;
		end
	end

	// reserved bits masked again on the way out
	assign next_bus_rdata = cfg_rd
		? (monitor_configuration & CFG_WMASK)
		: 8'h00;

	always @(posedge clk_i) begin
		if (rst_i) begin
			bus_rdata_o <= 8'h00;
		end else begin
			bus_rdata_o <= next_bus_rdata;
		end
	end

	assign monitor_mode_select =
		monitor_configuration[`AMC_MODE_MSB:`AMC_MODE_LSB];
	assign measure_done_irq_enable =
		monitor_configuration[`AMC_MDONE_IEN_BIT];
	assign threshold_event_irq_enable =
		monitor_configuration[`AMC_THR_IEN_BIT];
	assign threshold_polarity_select =
		monitor_configuration[`AMC_THR_POL_BIT];

	// state that the written mode field asks for
	always @* begin
		target_state = ST_OFF;
		case (monitor_mode_select)
			`AMC_MODE_OFF: begin
				target_state = ST_OFF;
			end
			`AMC_MODE_LEVEL: begin
				target_state = ST_LEVEL;
			end
			`AMC_MODE_CMP_BURST: begin
				target_state = ST_CMP;
			end
			`AMC_MODE_LOWPWR: begin
				target_state = ST_LOWPWR;
			end
			default: begin
				target_state = ST_OFF;
			end
		endcase
	end

	// start only matters when it changes the mode in use
	assign mode_change = start_i
		&& (target_state != mode_state);

	// without an accepted start the mode in use holds
	always @* begin
		next_mode_state = mode_state;
		if (mode_change) begin
			next_mode_state = target_state;
		end else begin
			next_mode_state = mode_state;
		end
	end

	// field code reported for the mode in use
	always @* begin
		next_active_mode = `AMC_MODE_OFF;
		case (next_mode_state)
			ST_OFF: begin
				next_active_mode = `AMC_MODE_OFF;
			end
			ST_LEVEL: begin
				next_active_mode = `AMC_MODE_LEVEL;
			end
			ST_CMP: begin
				next_active_mode = `AMC_MODE_CMP_BURST;
			end
			ST_LOWPWR: begin
				next_active_mode = `AMC_MODE_LOWPWR;
			end
			default: begin
				next_active_mode = `AMC_MODE_OFF;
			end
		endcase
	end

	// bursts start once per accepted start
	assign next_level_burst =
		mode_change && (target_state == ST_LEVEL);
	assign next_compare_burst =
		mode_change && (target_state == ST_CMP);
	// periodic run holds until another mode starts
	assign next_lowpwr_run =
		(next_mode_state == ST_LOWPWR);

	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_state <= ST_OFF;
		end else begin
			mode_state <= next_mode_state;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			active_mode_o <= `AMC_MODE_OFF;
		end else begin
			active_mode_o <= next_active_mode;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			flags_clear_o <= 1'h0;
		end else begin
			flags_clear_o <= mode_change;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			level_burst_o <= 1'h0;
		end else begin
			level_burst_o <= next_level_burst;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			compare_burst_o <= 1'h0;
		end else begin
			compare_burst_o <= next_compare_burst;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			lowpwr_run_o <= 1'h0;
		end else begin
			lowpwr_run_o <= next_lowpwr_run;
		end
	end

	// compare-done flag deliberately left out of the request
	assign measure_done_req =
		measure_done_flag_i && measure_done_irq_enable;
	assign threshold_req =
		threshold_crossed_flag_i && threshold_event_irq_enable;
	assign next_irq = measure_done_req || threshold_req;

	// polarity picks which comparator summary sets the flag
	assign selected_crossing = threshold_polarity_select
		? any_above_i
		: any_below_i;
	// no set in the cycle whose start clears the flags
	assign next_threshold_set = lowpwr_run_o
		&& selected_crossing
		&& !mode_change;

	always @(posedge clk_i) begin
		if (rst_i) begin
			threshold_set_o <= 1'h0;
		end else begin
			threshold_set_o <= next_threshold_set;
		end
	end

	// request follows the flags; a cleared flag drops it
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'h0;
		end else begin
			irq_o <= next_irq;
		end
	end

endmodule
`default_nettype wire

// file: core/amc_map.vh
/*
 * Address, field positions, reset value and mode codes of the analog
 * monitor configuration register.
 * Assumes inclusion by bare name from core design files.
 */
`ifndef AMC_MAP_VH
`define AMC_MAP_VH

`define AMC_ADDR_W          24
`define AMC_CFG_ADDR        24'h00FD42
`define AMC_CFG_RESET       8'h00
`define AMC_CFG_WMASK       8'h3B

`define AMC_MODE_LSB        0
`define AMC_MODE_MSB        1
`define AMC_MDONE_IEN_BIT   3
`define AMC_THR_IEN_BIT     4
`define AMC_THR_POL_BIT     5

`define AMC_MODE_OFF        2'h0
`define AMC_MODE_LEVEL      2'h1
`define AMC_MODE_CMP_BURST  2'h2
`define AMC_MODE_LOWPWR     2'h3

`endif

// file: tb/amc_config_asserts.sv
/* port checker for amc_config
   bound below; one clock, sync reset */
`timescale 1ns/1ns
`default_nettype none
module amc_asserts (
	input wire logic [7:0] bus_rdata_o,
	input wire logic [1:0] active_mode_o,
	input wire logic clk_i, rst_i, start_i, flags_clear_o, irq_o,
	input wire logic measure_done_flag_i, threshold_crossed_flag_i,
	input wire logic level_burst_o, compare_burst_o, lowpwr_run_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_st; !start_i |=> $stable(active_mode_o); endproperty
	a_st: assert property (p_st) else $error("mode moved");
	property p_clr; flags_clear_o |-> $changed(active_mode_o); endproperty
	a_clr: assert property (p_clr) else $error("bad clear");
	property p_lvl; level_burst_o |-> active_mode_o == 2'h1; endproperty
	a_lvl: assert property (p_lvl) else $error("bad level");
	property p_cmp; compare_burst_o |-> active_mode_o == 2'h2; endproperty
	a_cmp: assert property (p_cmp) else $error("bad compare");
	property p_lp; lowpwr_run_o == (active_mode_o == 2'h3); endproperty
	a_lp: assert property (p_lp) else $error("bad periodic");
	property p_off; !active_mode_o |-> !level_burst_o; endproperty
	a_off: assert property (p_off) else $error("off burst");
	property p_rsv; !(bus_rdata_o & 8'hC4); endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_irq;
		!measure_done_flag_i && !threshold_crossed_flag_i |=> !irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("stray irq");
	cover property (level_burst_o);
	cover property (lowpwr_run_o);
	cover property (irq_o);
endmodule
bind amc_config amc_asserts u_amc_asserts (.*);
`default_nettype wire

// file: tb/tb_analog_monitor_config.sv
/* bench for amc_config
   drives every port; clk_i 50 ns */
`timescale 1ns/1ns
`default_nettype none
module tb_analog_monitor_config;
	logic clk_i = 0, rst_i = 1, bus_wr_i = 0, bus_rd_i = 0, start_i = 0;
	logic measure_done_flag_i = 0, threshold_crossed_flag_i = 0;
	logic any_above_i = 0, any_below_i = 0, flags_clear_o, level_burst_o;
	logic compare_burst_o, lowpwr_run_o, threshold_set_o, irq_o;
	logic [23:0] bus_addr_i = 24'h00FD42;
	logic [7:0] bus_wdata_i = 8'h00, bus_rdata_o;
	logic [1:0] active_mode_o;
	int n_errors = 0, samples_checked = 0;
	amc_config u_amc_config (.*);
	initial forever #25 clk_i = ~clk_i;
	task tick; @(posedge clk_i); #1; endtask
	task ck(input string n, input logic [7:0] e, s);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] d);
		bus_addr_i = 24'h00FD42;
		bus_wdata_i = d;
		bus_wr_i = 1;
		tick;
		bus_wr_i = 0;
	endtask
	task rd(input logic [23:0] a, input logic [7:0] e);
		bus_addr_i = a;
		bus_rd_i = 1;
		tick;
		bus_rd_i = 0;
		ck("rdata", e, bus_rdata_o);
		tick;
	endtask
	task st; start_i = 1; tick; start_i = 0; endtask
	task conclude;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (6) tick;
		rst_i = 0;
		rd(24'h00FD42, 8'h00);
		wr(8'hFF); rd(24'h00FD42, 8'h3B);
		rd(24'h00FD43, 8'h00); ck("mode", 0, active_mode_o);
		$display("registers done");
		for (int m = 1; m < 5; m++) begin
			wr(m[1:0]); st; ck("mode", m % 4, active_mode_o);
			ck("pulse", {m % 4 == 1, m % 4 == 2, m % 4 == 3, 1'b1}, {level_burst_o,
				compare_burst_o, lowpwr_run_o, flags_clear_o});
			tick;
			st; ck("same", 0, flags_clear_o);
		end
		$display("modes done");
		wr(8'h03); st; any_below_i = 1; tick; ck("thr", 1, threshold_set_o);
		wr(8'h23); tick; ck("thr", 0, threshold_set_o);
		any_above_i = 1; tick; ck("thr", 1, threshold_set_o);
		$display("polarity done");
		wr(8'h08); measure_done_flag_i = 1; tick; ck("irq", 1, irq_o);
		wr(8'h10); tick; ck("irq", 0, irq_o);
		threshold_crossed_flag_i = 1; tick; ck("irq", 1, irq_o);
		threshold_crossed_flag_i = 0; tick; ck("irq", 0, irq_o);
		$display("irq done");
		conclude;
	end
endmodule
`default_nettype wire
